// ### src/mgsl_loader.sv
// Manual gain serial loader with parallel-port path selector
// Functional notes
// - A debounced send press sets the run latch and the serial clock runs while it is set.
// - Each serial clock period advances both the sequence and bit-select counters by one.
// - The operator's register select switches are latched for the transfer.
// - The loader returns idle after two periods in step-track, seven in direct-load.
// - The bit-select counter steers an eight-way mux that serialises the word.
// - The serial clock stays low whenever no word is being sent.
// - Direct-load mode writes the switch word straight into the selected gain registers.
// - Two select switches independently enable each gain register for a transfer.
// - Direct-load payload is the six-bit gain word from the switches.
// - Step-track payload is the single direction switch bit.
// - A two-way selector routes manual or parallel-port lines to the converter.
// - With the parallel-port path active it wins and the manual loader is halted.
`timescale 1ns/1ns
module mgsl_loader
    import mgsl_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned SCLK_HALF       = SCLK_HALF_CYC,
    parameter bit          MSB_FIRST       = 1'b1
)
(
    input  wire logic          clock_in,
    input  wire logic          rst_n_in,
    input  wire logic          send_button_ref_in,
    input  wire mgsl_switch_t  switch_in,
    input  wire mgsl_pc_t      pc_in,
    output mgsl_serial_t       serial_out,
    output logic               busy_out
);

    mgsl_core_t        q;
    mgsl_core_t        n;
    logic              press;
    logic              half_done;
    logic              last_period;
    logic [SEQ_W-1:0]  len;
    logic [GAIN_W-1:0] ordered;
    logic [MUX_W-1:0]  mux_word;
    logic              man_data;
    mgsl_serial_t      man;
    mgsl_serial_t      pc_route;

    // ****************************************************
    // Button filter
    // ****************************************************
    mgsl_debounce #(
        .SETTLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .button_in (send_button_ref_in),
        .press_out (press)
    );

    // ****************************************************
    // Payload shaping and eight-way mux
    // ****************************************************
    // Bit order chosen at build time
    genvar g;
    generate
        for (g = 0; g < GAIN_W; g = g + 1)
        begin : g_order
            assign ordered[g] = MSB_FIRST ? q.word[GAIN_W-1-g]
                                          : q.word[g];
        end
    endgenerate

    // Unused mux inputs read zero, so the tail period sends zero
    assign mux_word = (q.mode == MODE_DIRECT)
        ? {(MUX_W-GAIN_W)'(0), ordered}
        : {(MUX_W-1)'(0), q.word[DIR_BIT_IDX]};
    assign man_data = mux_word[q.bitsel];

    // Period count that ends a transfer
    assign len = (q.mode == MODE_DIRECT) ? SEQ_W'(LOAD_PERIODS)
                                         : SEQ_W'(TRACK_PERIODS);
    assign half_done   = q.div == DIV_W'(SCLK_HALF - 1);
    assign last_period = SEQ_W'(q.seq + SEQ_W'(1)) == len;

    // ****************************************************
    // Line selector inputs
    // ****************************************************
    always_comb
    begin
        man.serial_mode_select = q.mode;
        man.gain_reg1_select   = q.sel1;
        man.gain_reg2_select   = q.sel2;
        man.serial_clock       = (q.st == ST_HIGH);
        man.serial_gain_data   = (q.st != ST_IDLE) & man_data;
        pc_route.serial_mode_select = q.s2.pc.serial_mode_select;
        pc_route.gain_reg1_select   = q.s2.pc.gain_reg1_select;
        pc_route.gain_reg2_select   = q.s2.pc.gain_reg2_select;
        pc_route.serial_clock       = q.s2.pc.serial_clock;
        pc_route.serial_gain_data   = q.s2.pc.serial_gain_data;
    end

    // ****************************************************
    // Sequencer next state
    // ****************************************************
    always_comb
    begin
        n       = q;
        n.s1.sw = switch_in;
        n.s1.pc = pc_in;
        n.s2    = q.s1;
        case (q.st)
            ST_IDLE:
            begin
                // Mode follows the switch until a send starts
                n.mode   = q.s2.sw.serial_mode_select;
                n.div    = '0;
                n.seq    = '0;
                n.bitsel = '0;
                n.sel1   = IDLE_LEVEL;
                n.sel2   = IDLE_LEVEL;
                if (press && !q.s2.pc.active)
                begin
                    n.st   = ST_LOW;
                    n.sel1 = q.s2.sw.gain_reg1_select;
                    n.sel2 = q.s2.sw.gain_reg2_select;
                    // Word held so switch moves cannot tear it
                    n.word = q.s2.sw.gain_word;
                end
            end
            ST_LOW:
            begin
                if (half_done)
                begin
                    n.div = '0;
                    n.st  = ST_HIGH;
                end
                else
                begin
                    n.div = q.div + DIV_W'(1);
                end
            end
            ST_HIGH:
            begin
                if (half_done)
                begin
                    // Falling edge: advance both counters
                    n.div    = '0;
                    n.seq    = q.seq + SEQ_W'(1);
                    n.bitsel = q.bitsel + SEQ_W'(1);
                    if (last_period)
                    begin
                        n.st   = ST_IDLE;
                        n.sel1 = IDLE_LEVEL;
                        n.sel2 = IDLE_LEVEL;
                    end
                    else
                    begin
                        n.st = ST_LOW;
                    end
                end
                else
                begin
                    n.div = q.div + DIV_W'(1);
                end
            end
            default:
            begin
                n.st = ST_IDLE;
            end
        endcase
        // Host path takes over; a cut frame is simply dropped
        if (q.s2.pc.active && q.st != ST_IDLE)
        begin
            n.st   = ST_IDLE;
            n.sel1 = IDLE_LEVEL;
            n.sel2 = IDLE_LEVEL;
        end
        n.out  = q.s2.pc.active ? pc_route : man;
        n.busy = (n.st != ST_IDLE);
    end

    // ****************************************************
    // State register
    // ****************************************************
    // All zero after reset: idle, clock low, selects low
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= n;
    end

    assign serial_out = q.out;
    assign busy_out   = q.busy;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    // A send accepted from idle
    sequence s_start;
        q.st == ST_IDLE && press && !q.s2.pc.active;
    endsequence

    // Final falling edge of a transfer
    sequence s_end;
        q.st == ST_HIGH && half_done && last_period;
    endsequence

    // Falling edge that is not the last
    sequence s_step;
        q.st == ST_HIGH && half_done && !last_period;
    endsequence

    start_runs_clock_a: assert property (
        s_start |=> q.st == ST_LOW && q.busy)
        else $error("send press did not start the clock");

    press_ignored_a: assert property (
        q.st != ST_IDLE && press && !q.s2.pc.active
        |=> $stable(q.word))
        else $error("word reloaded during a transfer");

    step_advance_a: assert property (
        s_step |=> q.seq == $past(q.seq) + SEQ_W'(1)
                   && q.bitsel == $past(q.bitsel) + SEQ_W'(1)
                   && q.st == ST_LOW)
        else $error("counters did not advance on a period");

    selects_latched_a: assert property (
        s_start |=> q.sel1 == $past(q.s2.sw.gain_reg1_select)
                    && q.sel2 == $past(q.s2.sw.gain_reg2_select))
        else $error("register selects not latched at start");

    selects_clear_a: assert property (
        s_end |=> !q.sel1 && !q.sel2 ##1
                  !serial_out.gain_reg1_select
                  || q.s2.pc.active)
        else $error("register selects not released at end");

    period_count_a: assert property (
        q.st != ST_IDLE |-> q.seq < len)
        else $error("transfer ran past its period count");

    end_to_idle_a: assert property (
        (s_end and (!q.s2.pc.active))
        |=> q.st == ST_IDLE
            && $past(q.seq) == ((q.mode == MODE_DIRECT)
                ? SEQ_W'(LOAD_PERIODS - 1)
                : SEQ_W'(TRACK_PERIODS - 1)))
        else $error("transfer length wrong for mode");

    direct_payload_a: assert property (
        q.st != ST_IDLE && q.mode == MODE_DIRECT
        && q.bitsel < SEQ_W'(GAIN_W)
        |-> man_data == (MSB_FIRST
            ? q.word[GAIN_W - 1 - int'(q.bitsel)]
            : q.word[q.bitsel]))
        else $error("direct-load bit mismatch");

    track_payload_a: assert property (
        q.st != ST_IDLE && q.mode != MODE_DIRECT
        |-> man_data == (q.bitsel == SEQ_W'(0) && q.word[DIR_BIT_IDX]))
        else $error("step-track data not the direction bit");

    idle_quiet_a: assert property (
        q.st == ST_IDLE && !q.s2.pc.active
        |=> !serial_out.serial_clock
            && !serial_out.serial_gain_data)
        else $error("serial lines moved while idle");

    data_stable_high_a: assert property (
        q.st == ST_HIGH && $past(q.st) == ST_HIGH
        |-> $stable(man_data))
        else $error("data changed while clock high");

    pc_route_a: assert property (
        q.s2.pc.active |=> serial_out == $past(pc_route))
        else $error("parallel-port lines not routed");

    pc_halts_a: assert property (
        q.s2.pc.active |=> q.st == ST_IDLE ##1 !q.busy)
        else $error("manual loader ran with host active");

    // Unused mux inputs must send zero in the tail period
    tail_zero_a: assert property (
        q.st != ST_IDLE && q.mode == MODE_DIRECT
        && q.bitsel >= SEQ_W'(GAIN_W)
        |-> !man_data)
        else $error("direct-load tail bit not zero");

    // Mode is frozen once a send has started
    mode_hold_a: assert property (
        q.st != ST_IDLE |=> $stable(q.mode))
        else $error("mode changed during a transfer");

    half_len_a: assert property (
        q.st != ST_IDLE |-> q.div < DIV_W'(SCLK_HALF))
        else $error("half period ran too long");

    selects_out_a: assert property (
        q.st != ST_IDLE && !q.s2.pc.active
        |=> serial_out.gain_reg1_select == $past(q.sel1)
            && serial_out.gain_reg2_select == $past(q.sel2))
        else $error("register selects not driven out");

endmodule

// ### src/mgsl_pkg.sv
// Shared constants and types of the manual gain serial loader
package mgsl_pkg;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_PERIOD_NS    = 4;
    localparam int SCLK_PERIOD_NS   = 1000;
    // Longest half period, rounded down
    localparam int SCLK_HALF_CYC    = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int DEBOUNCE_TIME_US = 5000;
    // Least settle time, rounded up
    localparam int DEBOUNCE_CYC     =
        (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************
    // Sequence lengths and widths
    // ****************************************************
    localparam int TRACK_PERIODS = 2;
    localparam int LOAD_PERIODS  = 7;
    localparam int GAIN_W        = 6;
    localparam int MUX_W         = 8;
    localparam int SEQ_W         = 3;
    localparam int DIV_W         = 16;
    localparam int DEB_W         = 24;
    localparam int DIR_BIT_IDX   = 0;

    // ****************************************************
    // Encodings and reset values
    // ****************************************************
    localparam logic MODE_DIRECT = 1'b1;
    localparam logic IDLE_LEVEL  = 1'b0;
    localparam logic [DEB_W-1:0] DEB_CNT_RST = 24'h000000;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} mgsl_state_t;

    // Operator switches
    typedef struct packed {
        logic              serial_mode_select;
        logic              gain_reg1_select;
        logic              gain_reg2_select;
        logic [GAIN_W-1:0] gain_word;
    } mgsl_switch_t;

    // Parallel-port path
    typedef struct packed {
        logic active;
        logic serial_mode_select;
        logic gain_reg1_select;
        logic gain_reg2_select;
        logic serial_clock;
        logic serial_gain_data;
    } mgsl_pc_t;

    // Serial lines toward the converter
    typedef struct packed {
        logic serial_mode_select;
        logic gain_reg1_select;
        logic gain_reg2_select;
        logic serial_clock;
        logic serial_gain_data;
    } mgsl_serial_t;

    typedef struct packed {
        mgsl_switch_t sw;
        mgsl_pc_t     pc;
    } mgsl_pins_t;

    // Whole state of the loader
    typedef struct packed {
        mgsl_pins_t        s1;
        mgsl_pins_t        s2;
        mgsl_state_t       st;
        logic [DIV_W-1:0]  div;
        logic [SEQ_W-1:0]  seq;
        logic [SEQ_W-1:0]  bitsel;
        logic              mode;
        logic              sel1;
        logic              sel2;
        logic [GAIN_W-1:0] word;
        mgsl_serial_t      out;
        logic              busy;
    } mgsl_core_t;

    // Whole state of the button filter
    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             stable;
        logic [DEB_W-1:0] cnt;
        logic             press;
    } mgsl_deb_t;

endpackage

// ### src/mgsl_debounce.sv
// Push-button synchroniser and debounce filter with press pulse
`timescale 1ns/1ns
module mgsl_debounce
    import mgsl_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = DEBOUNCE_CYC
)
(
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic button_in,
    output logic      press_out
);

    mgsl_deb_t q;
    mgsl_deb_t n;
    logic      settled;

    // Level must hold unchanged for the whole settle time
    assign settled = q.cnt == DEB_W'(SETTLE_CYCLES - 1);

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        n       = q;
        n.s1    = button_in;
        n.s2    = q.s1;
        n.press = 1'b0;
        if (q.s2 == q.stable)
        begin
            n.cnt = DEB_CNT_RST;
        end
        else if (settled)
        begin
            // One pulse per accepted rising level
            n.cnt    = DEB_CNT_RST;
            n.stable = q.s2;
            n.press  = q.s2;
        end
        else
        begin
            n.cnt = q.cnt + DEB_W'(1);
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= n;
    end

    assign press_out = q.press;

    // One accepted press gives a single-cycle pulse
    press_pulse_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        q.press |=> !q.press)
        else $error("press pulse longer than one cycle");

endmodule

// ### testbench/mgsl_conv_model.sv
// Behavioural model of the converter's serial gain-register port
`timescale 1ns/1ns
module mgsl_conv_model
    import mgsl_pkg::*;
(
    input  wire logic          clock_in,
    input  wire logic          rst_n_in,
    input  wire logic          clr_in,
    input  wire mgsl_serial_t  line_in,
    output logic [7:0]         edges_out,
    output logic [7:0]         bits_out,
    output logic [2:0]         seen_out,
    output logic               skew_out,
    output logic [5:0]         reg1_out,
    output logic [5:0]         reg2_out
);
    logic       clk_q;
    logic       sel_q;
    logic [1:0] frame_sel;
    logic       frame_mode;
    logic       any_sel;

    assign any_sel = line_in.gain_reg1_select | line_in.gain_reg2_select;

    // Sample data on rising serial clock; apply word when selects drop
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            {clk_q, sel_q, frame_sel, frame_mode} <= '0;
            {edges_out, bits_out, seen_out, skew_out} <= '0;
            {reg1_out, reg2_out} <= '0;
        end
        else
        begin
            clk_q <= line_in.serial_clock;
            sel_q <= any_sel;
            if (clr_in)
            begin
                {edges_out, bits_out, seen_out, skew_out} <= '0;
            end
            else if (line_in.serial_clock && !clk_q)
            begin
                edges_out  <= edges_out + 8'h01;
                bits_out   <= {bits_out[6:0], line_in.serial_gain_data};
                seen_out   <= seen_out | line_in[4:2];
                frame_sel  <= line_in[3:2];
                frame_mode <= line_in.serial_mode_select;
            end
            else if (line_in.serial_clock &&
                     line_in.serial_gain_data !== bits_out[0])
            begin
                skew_out <= 1'b1;
            end
            // Register update only on a complete frame
            if (sel_q && !any_sel)
            begin
                if (frame_mode == MODE_DIRECT && edges_out == 8'h07)
                begin
                    if (frame_sel[1]) reg1_out <= bits_out[6:1];
                    if (frame_sel[0]) reg2_out <= bits_out[6:1];
                end
                else if (frame_mode != MODE_DIRECT && edges_out == 8'h02)
                begin
                    // One gain step up or down per transfer
                    if (frame_sel[1])
                        reg1_out <= bits_out[1] ? reg1_out + 6'h01
                                                : reg1_out - 6'h01;
                    if (frame_sel[0])
                        reg2_out <= bits_out[1] ? reg2_out + 6'h01
                                                : reg2_out - 6'h01;
                end
            end
        end
    end
endmodule

// ### testbench/manual_gain_serial_loader_tb.sv
// Self-checking bench of the manual gain serial loader
`timescale 1ns/1ns
module manual_gain_serial_loader_tb;
    import mgsl_pkg::*;

    typedef struct packed {
        logic       mode;
        logic       s1;
        logic       s2;
        logic [5:0] word;
        logic [7:0] edges;
        logic [7:0] bits;
    } mgsl_row_t;

    // Track rows keep the five upper word switches at zero
    localparam mgsl_row_t ROWS [0:5] = '{
        '{1'b1, 1'b1, 1'b1, 6'h2D, 8'h07, 8'h5A},
        '{1'b1, 1'b1, 1'b0, 6'h3F, 8'h07, 8'h7E},
        '{1'b1, 1'b0, 1'b1, 6'h01, 8'h07, 8'h02},
        '{1'b1, 1'b0, 1'b0, 6'h15, 8'h07, 8'h2A},
        '{1'b0, 1'b1, 1'b1, 6'h00, 8'h02, 8'h00},
        '{1'b0, 1'b0, 1'b1, 6'h01, 8'h02, 8'h02}};

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         button = 1'b0;
    logic         clr = 1'b0;
    mgsl_switch_t sw = '0;
    mgsl_pc_t     pc = '0;
    mgsl_serial_t line;
    logic         busy;
    logic [7:0]   edges;
    logic [7:0]   bits;
    logic [2:0]   seen;
    logic         skew;
    logic [5:0]   reg1;
    logic [5:0]   reg2;
    logic [5:0]   r1 = 6'h00;
    logic [5:0]   r2 = 6'h00;
    int           num_errors = 0;
    int           compares = 0;

    always #2 clk = ~clk;

    mgsl_loader #(.DEBOUNCE_CYCLES(4), .SCLK_HALF(2), .MSB_FIRST(1'b1)) dut (
        .clock_in           (clk),
        .rst_n_in           (rst_n),
        .send_button_ref_in (button),
        .switch_in          (sw),
        .pc_in              (pc),
        .serial_out         (line),
        .busy_out           (busy)
    );

    mgsl_conv_model conv (
        .clock_in  (clk),
        .rst_n_in  (rst_n),
        .clr_in    (clr),
        .line_in   (line),
        .edges_out (edges),
        .bits_out  (bits),
        .seen_out  (seen),
        .skew_out  (skew),
        .reg1_out  (reg1),
        .reg2_out  (reg2)
    );

    // ****************************************************
    // Helpers
    // ****************************************************
    task automatic final_report();
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait; a hang ends the run
    task automatic wait_busy(input logic lvl);
        int n = 0;
        while (busy !== lvl && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000)
        begin
            num_errors++;
            $display("Error at %0t: busy wait %h", $time, lvl);
            final_report();
        end
    endtask

    task automatic clear_model();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        repeat (8) @(posedge clk);
        chk8({2'b00, line, busy}, 8'h00);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Table of ordinary transfers
        foreach (ROWS[i])
        begin
            @(posedge clk) sw <= ROWS[i][24:16];
            clear_model();
            @(posedge clk) button <= 1'b1;
            wait_busy(1'b1);
            @(posedge clk) button <= 1'b0;
            wait_busy(1'b0);
            repeat (6) @(posedge clk);
            if (ROWS[i].mode == MODE_DIRECT)
            begin
                if (ROWS[i].s1) r1 = ROWS[i].word;
                if (ROWS[i].s2) r2 = ROWS[i].word;
            end
            else
            begin
                if (ROWS[i].s1) r1 = ROWS[i].word[0] ? r1 + 6'h01
                                                     : r1 - 6'h01;
                if (ROWS[i].s2) r2 = ROWS[i].word[0] ? r2 + 6'h01
                                                     : r2 - 6'h01;
            end
            chk8(edges, ROWS[i].edges);
            chk8(bits, ROWS[i].bits);
            chk8({5'h00, seen}, {5'h00, ROWS[i][24:22]});
            chk8({7'h00, skew}, 8'h00);
            chk8({2'b00, reg1}, {2'b00, r1});
            chk8({2'b00, reg2}, {2'b00, r2});
        end
        // Second press during a transfer is ignored
        @(posedge clk) sw <= {1'b1, 1'b1, 1'b1, 6'h2A};
        clear_model();
        @(posedge clk) button <= 1'b1;
        wait_busy(1'b1);
        @(posedge clk) button <= 1'b0;
        // Long enough for the filter to see a real release
        repeat (10) @(posedge clk);
        button <= 1'b1;
        wait_busy(1'b0);
        button <= 1'b0;
        repeat (60) @(posedge clk);
        chk8({7'h00, busy}, 8'h00);
        chk8(edges, 8'h07);
        chk8(bits, 8'h54);
        // Host path takes over in mid-transfer
        clear_model();
        @(posedge clk) button <= 1'b1;
        wait_busy(1'b1);
        repeat (6) @(posedge clk);
        pc <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        button <= 1'b0;
        repeat (5) @(posedge clk);
        chk8({7'h00, busy}, 8'h00);
        chk8({3'b000, line}, 8'h15);
        clear_model();
        // Host serial clock, 64 ns period; manual press refused
        button <= 1'b1;
        repeat (5)
        begin
            repeat (8) @(posedge clk);
            pc.serial_clock <= 1'b1;
            repeat (8) @(posedge clk);
            pc.serial_clock <= 1'b0;
        end
        button <= 1'b0;
        repeat (5) @(posedge clk);
        chk8(edges, 8'h05);
        chk8({7'h00, busy}, 8'h00);
        pc <= '0;
        repeat (30) @(posedge clk);
        chk8({6'h00, busy, line.serial_clock}, 8'h00);
        // Reset in mid-transfer drops the frame
        @(posedge clk) button <= 1'b1;
        wait_busy(1'b1);
        button <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk8({2'b00, line, busy}, 8'h00);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk8({7'h00, busy}, 8'h00);
        final_report();
    end
endmodule
